// [core/simd_alu_map.vh]
// Purpose: Constants for the packed SIMD integer datapath.
// Assumes: 64-bit operands, one operation code per request.
// Notes: Included by the datapath top and its checker.
//
// Notes on behaviour
// - Signed word max returns the larger signed value in each of four lanes.
// - Signed word min returns the smaller signed value in each of four lanes.
// - Unsigned byte max returns the larger unsigned value in each byte lane.
// - Unsigned byte min returns the smaller unsigned value in each byte lane.
// - High multiply gives upper 16 bits of each signed or unsigned word product.
// - Byte absolute differences are summed into word 0; upper words are zero.
// - Average adds elements with carry-in, then shifts each sum right once.
// - Average keeps each lane's carry out as the shifted result's top bit.
// - Byte average uses unsigned byte lanes, word average unsigned word lanes.
// - Average writes a register result; source may be register or memory.
// - Saturating add and subtract exist only for byte and word lanes.
// - Subtract saturation follows operand signedness; no signed-in unsigned-out form.
// - Plain word subtract wraps modulo 2^16, so negating 8000 hex gives 8000 hex.
// - Multiply-add does four 16-bit products and two additions per operand.
`ifndef SIMD_ALU_MAP_VH
`define SIMD_ALU_MAP_VH

`define OP_W 5
`define OP_MAXSW 5'h00
`define OP_MINSW 5'h01
`define OP_MAXUB 5'h02
`define OP_MINUB 5'h03
`define OP_MULHUW 5'h04
`define OP_MULHW 5'h05
`define OP_SADBW 5'h06
`define OP_AVGB 5'h07
`define OP_AVGW 5'h08
`define OP_MADDWD 5'h09
`define OP_ADDSB 5'h0a
`define OP_ADDSW 5'h0b
`define OP_ADDUSB 5'h0c
`define OP_ADDUSW 5'h0d
`define OP_SUBSB 5'h0e
`define OP_SUBSW 5'h0f
`define OP_SUBUSB 5'h10
`define OP_SUBUSW 5'h11
`define OP_ADDW 5'h12
`define OP_SUBW 5'h13
`define AVG_CARRY_IN 1'b1

`endif

// [core/word_lane_mul.v]
// Purpose: One 16x16 word multiplier lane, signed or unsigned.
// Assumes: Purely combinational; the caller registers the product.
// Notes: Full 32-bit product is returned.
`timescale 1ns/1ps
`default_nettype none
module word_lane_mul (
   input wire [15:0] i_a,
   input wire [15:0] i_b,
   input wire i_signed,
   output wire [31:0] o_prod
);
   wire [16:0] a_ext;
   wire [16:0] b_ext;
   wire signed [33:0] full;

   assign a_ext = {i_signed & i_a[15], i_a};
   assign b_ext = {i_signed & i_b[15], i_b};
   assign full = $signed(a_ext) * $signed(b_ext);
   assign o_prod = full[31:0];
endmodule
`default_nettype wire

// [core/byte_abs_diff.v]
// Purpose: Absolute difference of two unsigned bytes.
// Assumes: Purely combinational.
// Notes: Used by the sum of absolute differences.
`timescale 1ns/1ps
`default_nettype none
module byte_abs_diff (
   input wire [7:0] i_a,
   input wire [7:0] i_b,
   output wire [7:0] o_diff
);
   assign o_diff = (i_a >= i_b) ? (i_a - i_b) : (i_b - i_a);
endmodule
`default_nettype wire

// [core/simd_int_alu.v]
// Purpose: Packed SIMD integer max/min, high multiply, SAD, average,
//          multiply-add and saturating add/subtract on 64-bit operands.
// Assumes: Operands already selected from register file or load unit.
// Notes: One cycle latency; o_valid pulses with the registered result.
`timescale 1ns/1ps
`default_nettype none
`include "simd_alu_map.vh"
module simd_int_alu (
   input wire i_clk,
   input wire i_rst_n,
   input wire i_valid,
   input wire [4:0] i_op,
   input wire [63:0] i_dst,
   input wire [63:0] i_src,
   input wire i_src_mem,
   output reg o_valid,
   output reg [63:0] o_result,
   output reg o_src_mem
);

   ////////////////////////////////////////////////////////////////////
   wire [63:0] maxsw;
   wire [63:0] minsw;
   wire [63:0] mulh;
   wire [63:0] avgw;
   wire [63:0] addsw;
   wire [63:0] addusw;
   wire [63:0] subsw;
   wire [63:0] subusw;
   wire [63:0] addw;
   wire [63:0] subw;
   wire [127:0] prods;
   wire [63:0] maxub;
   wire [63:0] minub;
   wire [63:0] avgb;
   wire [63:0] addsb;
   wire [63:0] addusb;
   wire [63:0] subsb;
   wire [63:0] subusb;
   wire [63:0] absd;
   wire mul_signed;

   // Only the signed high multiply and multiply-add extend the sign bit.
   assign mul_signed = (i_op == `OP_MULHW) || (i_op == `OP_MADDWD);

   localparam WORD_LANES = 4;
   localparam BYTE_LANES = 8;

   genvar w;
   generate
      for (w = 0; w < WORD_LANES; w = w + 1) begin : g_word
         wire [15:0] a;
         wire [15:0] b;

         wire [16:0] usum;
         wire [16:0] udif;
         wire [16:0] ssum;
         wire [16:0] sdif;

         wire [16:0] avg_cin;
         wire [16:0] avg_sum;
         wire [31:0] p;

         wire s_gt;
         wire s_lt;
         wire add_ovf;
         wire sub_ovf;
         wire [15:0] add_lim;
         wire [15:0] sub_lim;

         assign a = i_dst[16*w+15:16*w];
         assign b = i_src[16*w+15:16*w];

         // Lane-local sums keep every carry and borrow inside the lane.
         assign usum = {1'b0, a} + {1'b0, b};
         assign udif = {1'b0, a} - {1'b0, b};
         assign ssum = {a[15], a} + {b[15], b};
         assign sdif = {a[15], a} - {b[15], b};

         assign s_gt = $signed(a) > $signed(b);
         assign s_lt = $signed(a) < $signed(b);
         assign maxsw[16*w+15:16*w] = s_gt ? a : b;
         assign minsw[16*w+15:16*w] = s_lt ? a : b;

         word_lane_mul u_mul (
            .i_a(a),
            .i_b(b),
            .i_signed(mul_signed),
            .o_prod(p)
         );
         assign prods[32*w+31:32*w] = p;
         assign mulh[16*w+15:16*w] = p[31:16];

         assign avg_cin = {16'h0000, `AVG_CARRY_IN};
         assign avg_sum = {1'b0, a} + {1'b0, b} + avg_cin;
         // Carry out lands in bit 15 after the shift.
         assign avgw[16*w+15:16*w] = avg_sum[16:1];

         // Saturation kind follows operand signedness.
         assign add_ovf = ssum[16] != ssum[15];
         assign sub_ovf = sdif[16] != sdif[15];
         assign add_lim = ssum[16] ? 16'h8000 : 16'h7fff;
         assign sub_lim = sdif[16] ? 16'h8000 : 16'h7fff;
         assign addsw[16*w+15:16*w] = add_ovf ? add_lim : ssum[15:0];
         assign addusw[16*w+15:16*w] = usum[16] ? 16'hffff : usum[15:0];
         assign subsw[16*w+15:16*w] = sub_ovf ? sub_lim : sdif[15:0];
         assign subusw[16*w+15:16*w] = udif[16] ? 16'h0000 : udif[15:0];

         assign addw[16*w+15:16*w] = usum[15:0];
         // Wraps, so 0 - 8000 hex stays 8000 hex.
         assign subw[16*w+15:16*w] = udif[15:0];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////
   genvar k;
   generate
      for (k = 0; k < BYTE_LANES; k = k + 1) begin : g_byte
         wire [7:0] a;
         wire [7:0] b;

         wire [8:0] usum;
         wire [8:0] udif;
         wire [8:0] ssum;
         wire [8:0] sdif;

         wire [8:0] avg_cin;
         wire [8:0] avg_sum;

         wire u_gt;
         wire u_lt;
         wire add_ovf;
         wire sub_ovf;
         wire [7:0] add_lim;
         wire [7:0] sub_lim;

         assign a = i_dst[8*k+7:8*k];
         assign b = i_src[8*k+7:8*k];

         assign usum = {1'b0, a} + {1'b0, b};
         assign udif = {1'b0, a} - {1'b0, b};
         assign ssum = {a[7], a} + {b[7], b};
         assign sdif = {a[7], a} - {b[7], b};

         assign u_gt = a > b;
         assign u_lt = a < b;
         assign maxub[8*k+7:8*k] = u_gt ? a : b;
         assign minub[8*k+7:8*k] = u_lt ? a : b;

         assign avg_cin = {8'h00, `AVG_CARRY_IN};
         assign avg_sum = {1'b0, a} + {1'b0, b} + avg_cin;
         // The ninth sum bit becomes the top result bit.
         assign avgb[8*k+7:8*k] = avg_sum[8:1];

         assign add_ovf = ssum[8] != ssum[7];
         assign sub_ovf = sdif[8] != sdif[7];
         assign add_lim = ssum[8] ? 8'h80 : 8'h7f;
         assign sub_lim = sdif[8] ? 8'h80 : 8'h7f;
         assign addsb[8*k+7:8*k] = add_ovf ? add_lim : ssum[7:0];
         assign addusb[8*k+7:8*k] = usum[8] ? 8'hff : usum[7:0];
         assign subsb[8*k+7:8*k] = sub_ovf ? sub_lim : sdif[7:0];
         assign subusb[8*k+7:8*k] = udif[8] ? 8'h00 : udif[7:0];

         byte_abs_diff u_absd (
            .i_a(a),
            .i_b(b),
            .o_diff(absd[8*k+7:8*k])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////
   // Eight bytes of at most ff hex sum to at most 7f8 hex, so 11 bits never overflow.
   // A running chain keeps each adder narrow at the cost of a deeper path.
   wire [10:0] sad_acc [0:8];
   wire [10:0] sad_sum;
   wire [63:0] sad_word;
   assign sad_acc[0] = 11'h000;
   genvar s;
   generate
      for (s = 0; s < BYTE_LANES; s = s + 1) begin : g_sad
         assign sad_acc[s+1] = sad_acc[s] + {3'b000, absd[8*s+7:8*s]};
      end
   endgenerate
   assign sad_sum = sad_acc[8];
   assign sad_word = {48'h0, 5'h00, sad_sum};

   // Adjacent signed products summed; the 32-bit add wraps on overflow.
   wire [31:0] prod0;
   wire [31:0] prod1;
   wire [31:0] prod2;
   wire [31:0] prod3;
   wire [31:0] madd_lo;
   wire [31:0] madd_hi;
   wire [63:0] madd_word;
   assign prod0 = prods[31:0];
   assign prod1 = prods[63:32];
   assign prod2 = prods[95:64];
   assign prod3 = prods[127:96];
   assign madd_lo = prod0 + prod1;
   assign madd_hi = prod2 + prod3;
   assign madd_word = {madd_hi, madd_lo};

   ////////////////////////////////////////////////////////////////////
   reg [63:0] result_next;
   // Unknown codes give zero rather than a stale lane result.
   always @* begin
      case (i_op)
         `OP_MAXSW: begin
            result_next = maxsw;
         end
         `OP_MINSW: begin
            result_next = minsw;
         end
         `OP_MAXUB: begin
            result_next = maxub;
         end
         `OP_MINUB: begin
            result_next = minub;
         end
         `OP_MULHUW: begin
            result_next = mulh;
         end
         `OP_MULHW: begin
            result_next = mulh;
         end
         `OP_SADBW: begin
            result_next = sad_word;
         end
         `OP_AVGB: begin
            result_next = avgb;
         end
         `OP_AVGW: begin
            result_next = avgw;
         end
         `OP_MADDWD: begin
            result_next = madd_word;
         end
         `OP_ADDSB: begin
            result_next = addsb;
         end
         `OP_ADDSW: begin
            result_next = addsw;
         end
         `OP_ADDUSB: begin
            result_next = addusb;
         end
         `OP_ADDUSW: begin
            result_next = addusw;
         end
         `OP_SUBSB: begin
            result_next = subsb;
         end
         `OP_SUBSW: begin
            result_next = subsw;
         end
         `OP_SUBUSB: begin
            result_next = subusb;
         end
         `OP_SUBUSW: begin
            result_next = subusw;
         end
         `OP_ADDW: begin
            result_next = addw;
         end
         `OP_SUBW: begin
            result_next = subw;
         end
         default: begin
            result_next = 64'h0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // The whole 64-bit destination updates on one edge.
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_result <= 64'h0;
      end else begin
         if (i_valid) begin
            o_result <= result_next;
         end
      end
   end

   // The strobe follows every request, known code or not.
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_valid <= 1'b0;
      end else begin
         o_valid <= i_valid;
      end
   end

   // The memory tag is echoed every cycle; it never gates the result.
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_src_mem <= 1'b0;
      end else begin
         o_src_mem <= i_src_mem;
      end
   end
endmodule
`default_nettype wire

// [dv/simd_alu_checker_assertions.sv]
// Purpose: Port checks for the packed SIMD datapath.
// Assumes: One cycle from accepted request to result.
// Notes: Only lane samples are checked here; the bench covers all lanes.
`timescale 1ns/1ps
`default_nettype none
`include "simd_alu_map.vh"
module simd_alu_checker (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_valid,
   input wire logic [4:0] i_op,
   input wire logic [63:0] i_dst,
   input wire logic [63:0] i_src,
   input wire logic i_src_mem,
   input wire logic o_valid,
   input wire logic [63:0] o_result,
   input wire logic o_src_mem
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   wire logic [8:0] avg0 = {1'b0, i_dst[7:0]} + i_src[7:0] + 9'h001;
   wire logic [7:0] umax0 = i_dst[7:0] > i_src[7:0] ? i_dst[7:0] : i_src[7:0];
   wire logic [15:0] smin3 = $signed(i_dst[63:48]) < $signed(i_src[63:48]) ?
      i_dst[63:48] : i_src[63:48];
   wire logic [31:0] uprod1 = i_dst[31:16] * i_src[31:16];
   ////////////////////////////////////////////////////////////////////////////////
   a_result_follows: assert property (i_valid |=> o_valid)
      else $error("result strobe missing");
   a_no_spurious: assert property (!i_valid |=> !o_valid)
      else $error("result strobe without request");
   a_result_holds: assert property (!i_valid |=> $stable(o_result))
      else $error("result moved while idle");
   a_sad_upper: assert property (i_valid && i_op == `OP_SADBW |=> o_result[63:16] == 48'h0)
      else $error("sad upper words not clear");
   a_maxub_lane: assert property (i_valid && i_op == `OP_MAXUB |=> o_result[7:0] == $past(umax0))
      else $error("unsigned byte max wrong");
   a_minsw_lane: assert property (i_valid && i_op == `OP_MINSW |=> o_result[63:48] == $past(smin3))
      else $error("signed word min wrong");
   a_avg_round: assert property (i_valid && i_op == `OP_AVGB |=> o_result[7:0] == $past(avg0[8:1]))
      else $error("byte average wrong");
   a_mulh_high: assert property (i_valid && i_op == `OP_MULHUW |=> o_result[31:16] == $past(uprod1[31:16]))
      else $error("high multiply wrong");
   a_wrap_neg: assert property (i_valid && i_op == `OP_SUBW && i_dst[15:0] == 16'h0 && i_src[15:0] == 16'h8000 |=> o_result[15:0] == 16'h8000)
      else $error("word subtract did not wrap");
   a_mem_echo: assert property (i_valid |=> o_src_mem == $past(i_src_mem))
      else $error("memory tag not echoed");
endmodule
bind simd_int_alu simd_alu_checker i_chk (.i_clk, .i_rst_n, .i_valid, .i_op, .i_dst, .i_src,
   .i_src_mem, .o_valid, .o_result, .o_src_mem);
`default_nettype wire

// [dv/operand_issue.sv]
// Purpose: Issue-side model that hands operands to the datapath.
// Assumes: The bench queues one request per cycle.
// Notes: Idle operand lines toggle, as no stage holds them then.
`timescale 1ns/1ps
`default_nettype none
module operand_issue (
   input wire logic i_clk,
   input wire logic i_req,
   input wire logic [133:0] i_word,
   output logic o_valid,
   output logic [133:0] o_word
);
   initial o_valid = 1'b0;
   initial o_word = 134'h0;
   always @(negedge i_clk) begin
      o_valid <= i_req;
      o_word <= i_req ? i_word : ~o_word;
   end
endmodule
`default_nettype wire

// [dv/testbench.sv]
// Purpose: Self-checking bench for the packed SIMD datapath.
// Assumes: Results return in request order.
// Notes: Every op code, corner operands and random operands.
`timescale 1ns/1ps
`default_nettype none
`include "simd_alu_map.vh"
module testbench;
   logic i_clk = 1'b0, i_rst_n = 1'b0, req = 1'b0, ov, om, v;
   logic [133:0] wd = 134'h0, w;
   logic [63:0] res;
   logic [64:0] q[$];
   logic [15:0] rnd = 16'h5849;
   int err_total = 0, check_count = 0;
   always #2.5 i_clk = ~i_clk;
   operand_issue i_operand_issue (.i_clk(i_clk), .i_req(req), .i_word(wd), .o_valid(v),
      .o_word(w));
   simd_int_alu i_simd_int_alu (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_valid(v),
      .i_op(w[132:128]), .i_dst(w[127:64]), .i_src(w[63:0]), .i_src_mem(w[133]),
      .o_valid(ov), .o_result(res), .o_src_mem(om));
   ////////////////////////////////////////////////////////////////////////////////
   function automatic longint clp(input longint x, lo, hi);
      clp = x < lo ? lo : (x > hi ? hi : x);
   endfunction
   function automatic [63:0] model(input [4:0] op, input [63:0] a, b);
      longint k, n, m, x, y, u, v, s, d0, d1;
      begin
         model = 64'h0; s = 0; d0 = 0; d1 = 0;
         n = op inside {`OP_MAXUB, `OP_MINUB, `OP_SADBW, `OP_AVGB, `OP_ADDSB, `OP_ADDUSB,
            `OP_SUBSB, `OP_SUBUSB} ? 8 : 16;
         m = 1 << n;
         for (k = 0; k < 64 / n; k++) begin
            x = (a >> k * n) & (m - 1);
            y = (b >> k * n) & (m - 1);
            u = x >= m / 2 ? x - m : x;
            v = y >= m / 2 ? y - m : y;
            case (op)
               `OP_MAXSW: x = u > v ? u : v;
               `OP_MINSW: x = u < v ? u : v;
               `OP_MAXUB: x = x > y ? x : y;
               `OP_MINUB: x = x < y ? x : y;
               `OP_MULHUW: x = x * y >> 16;
               `OP_MULHW: x = u * v >>> 16;
               `OP_SADBW: s += x > y ? x - y : y - x;
               `OP_AVGB, `OP_AVGW: x = (x + y + 1) >> 1;
               `OP_MADDWD: if (k < 2) d0 += u * v; else d1 += u * v;
               `OP_ADDSB, `OP_ADDSW: x = clp(u + v, -m / 2, m / 2 - 1);
               `OP_ADDUSB, `OP_ADDUSW: x = clp(x + y, 0, m - 1);
               `OP_SUBSB, `OP_SUBSW: x = clp(u - v, -m / 2, m / 2 - 1);
               `OP_SUBUSB, `OP_SUBUSW: x = clp(x - y, 0, m - 1);
               `OP_ADDW: x = x + y;
               `OP_SUBW: x = x - y;
               default: x = 0;
            endcase
            model |= (x & (m - 1)) << k * n;
         end
         if (op == `OP_SADBW) model = s;
         if (op == `OP_MADDWD) model = {d1[31:0], d0[31:0]};
      end
   endfunction
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input string name, input [64:0] seen, exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH %s exp %h seen %h", name, exp, seen);
      end
   endtask
   task automatic test_done;
      if (err_total == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   function automatic [15:0] lfsr(input [15:0] s);
      lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic draw(output [63:0] d);
      repeat (4) begin
         rnd = lfsr(rnd);
         d = {d[47:0], rnd};
      end
   endtask
   task automatic issue(input [4:0] op, input [63:0] a, b, input m);
      @(negedge i_clk);
      req <= 1'b1;
      wd <= {m, op, a, b};
      q.push_back({m, model(op, a, b)});
   endtask
   always @(negedge i_clk) if (ov === 1'b1) check("result", {om, res}, q.pop_front());
   initial begin
      #50000;
      err_total++;
      test_done;
   end
   initial begin
      logic [63:0] a, b;
      repeat (6) @(negedge i_clk);
      check("reset", {ov, res}, 65'h0);
      check("reset tag", {64'h0, om}, 65'h0);
      i_rst_n <= 1'b1;
      for (int k = 0; k < 22; k++) begin
         issue(5'(k), 64'h8000800080008000, 64'h8000800080008000, 1'b0);
         issue(5'(k), 64'h0, 64'h7fff80007f808000, 1'b1);
         issue(5'(k), 64'hffffffffffffffff, 64'h7fff80017f80ff01, 1'b0);
         for (int n = 0; n < 40; n++) begin
            draw(a);
            draw(b);
            issue(5'(k), a, b, rnd[0]);
         end
         @(negedge i_clk) req <= 1'b0;
         if (k == 9) begin
            repeat (2) @(negedge i_clk);
            i_rst_n <= 1'b0;
            @(negedge i_clk);
            check("mid reset", {ov, res}, 65'h0);
            check("mid reset tag", {64'h0, om}, 65'h0);
            i_rst_n <= 1'b1;
         end
      end
      repeat (3) @(negedge i_clk);
      check("pending", {1'b0, 64'(q.size())}, 65'h0);
      test_done;
   end
endmodule
`default_nettype wire
